// [sclr_regs.sv]
`include "sclr_map.svh"
module sclr_regs #(
	parameter logic [15:0] UP_CAP  = `SCLR_UP_CAP_DEF,
	parameter logic [15:0] DN_CAP  = `SCLR_DN_CAP_DEF,
	parameter bit          SEP_BUF = 1'b1
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// configuration access: idx 0 upstream, 1 downstream
	input  wire logic              cfg_wr,
	input  wire logic              cfg_rd,
	input  wire logic              cfg_idx,
	input  wire logic [31:0]       cfg_wdata,
	input  wire logic [3:0]        cfg_be,
	output logic [31:0]            cfg_rdata_ff,
	// delayed-request flag, cleared by writing one
	input  wire logic              dly_clr,
	output logic                   dly_flag_ff,
	// upstream requests and completions
	input  wire logic              up_req_valid,
	input  wire sclr_pkg::sclr_kind_t up_req_kind,
	input  wire sclr_pkg::sclr_adq_t up_req_size,
	input  wire logic              up_cpl_valid,
	input  wire sclr_pkg::sclr_kind_t up_cpl_kind,
	input  wire sclr_pkg::sclr_adq_t up_cpl_size,
	output logic                   up_fwd_ff,
	output logic                   up_held_ff,
	// downstream requests and completions
	input  wire logic              dn_req_valid,
	input  wire sclr_pkg::sclr_kind_t dn_req_kind,
	input  wire sclr_pkg::sclr_adq_t dn_req_size,
	input  wire logic              dn_cpl_valid,
	input  wire sclr_pkg::sclr_kind_t dn_cpl_kind,
	input  wire sclr_pkg::sclr_adq_t dn_cpl_size,
	output logic                   dn_fwd_ff,
	output logic                   dn_held_ff
);
	logic                up_we;
	logic                dn_we;
	sclr_pkg::sclr_adq_t up_lim;
	sclr_pkg::sclr_adq_t dn_lim;
	sclr_pkg::sclr_adq_t up_out;
	sclr_pkg::sclr_adq_t dn_out;
	sclr_pkg::sclr_adq_t up_wd;
	sclr_pkg::sclr_adq_t dn_wd;

	// only the limit half takes writes; capacity bytes are ignored
	assign up_we = cfg_wr && cfg_idx == `SCLR_IDX_UP
		&& (cfg_be[2] || cfg_be[3]);
	assign dn_we = cfg_wr && cfg_idx == `SCLR_IDX_DN
		&& (cfg_be[2] || cfg_be[3]);
	// byte lanes merge over the current limit
	assign up_wd = {cfg_be[3] ? cfg_wdata[31:24] : up_lim[15:8],
		cfg_be[2] ? cfg_wdata[23:16] : up_lim[7:0]};
	assign dn_wd = {cfg_be[3] ? cfg_wdata[31:24] : dn_lim[15:8],
		cfg_be[2] ? cfg_wdata[23:16] : dn_lim[7:0]};

	sclr_dir #(.CAP(UP_CAP), .SEP_BUF(SEP_BUF)) u_up (
		.core_clk (core_clk),
		.rst      (rst),
		.lim_we   (up_we),
		.lim_wdata(up_wd),
		.req_valid(up_req_valid),
		.req_kind (up_req_kind),
		.req_size (up_req_size),
		.cpl_valid(up_cpl_valid),
		.cpl_kind (up_cpl_kind),
		.cpl_size (up_cpl_size),
		.fwd_ff   (up_fwd_ff),
		.held_ff  (up_held_ff),
		.limit_ff (up_lim),
		.outst_ff (up_out)
	);

	sclr_dir #(.CAP(DN_CAP), .SEP_BUF(SEP_BUF)) u_dn (
		.core_clk (core_clk),
		.rst      (rst),
		.lim_we   (dn_we),
		.lim_wdata(dn_wd),
		.req_valid(dn_req_valid),
		.req_kind (dn_req_kind),
		.req_size (dn_req_size),
		.cpl_valid(dn_cpl_valid),
		.cpl_kind (dn_cpl_kind),
		.cpl_size (dn_cpl_size),
		.fwd_ff   (dn_fwd_ff),
		.held_ff  (dn_held_ff),
		.limit_ff (dn_lim),
		.outst_ff (dn_out)
	);

	// read data registered; capacity comes from parameters only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_rdata_ff <= 32'h0000_0000;
		end else if (cfg_rd) begin
			cfg_rdata_ff <= (cfg_idx == `SCLR_IDX_UP)
				? {up_lim, UP_CAP}
				: {dn_lim, DN_CAP};
		end
	end

	// an upstream hold sets, and a set in the clear cycle wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dly_flag_ff <= 1'b0;
		end else if (up_req_valid && !up_fwd_ok()) begin
			dly_flag_ff <= 1'b1;
		end else if (dly_clr) begin
			dly_flag_ff <= 1'b0;
		end
	end

	// mirrors the upstream gate in the same cycle so the flag sets on the same edge as up_held_ff
	function automatic logic up_fwd_ok();
		logic        cnt;
		logic [16:0] w;
		cnt = SEP_BUF ? (up_req_kind == sclr_pkg::SCLR_KIND_MEMRD) : 1'b1;
		w = {1'b0, up_out} + {1'b0, up_req_size};
		return (up_lim == `SCLR_LIM_OFF) || !cnt || (w <= {1'b0, up_lim});
	endfunction

	a_cap_read: assert property (@(posedge core_clk) disable iff (rst)
		cfg_rd |=> cfg_rdata_ff[15:0] == ($past(cfg_idx) ? DN_CAP : UP_CAP))
		else $error("capacity field read wrong");
	a_reset_lim: assert property (@(posedge core_clk)
		$fell(rst) |-> up_lim == UP_CAP && dn_lim == DN_CAP)
		else $error("limit not equal capacity after reset");
	a_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
		up_held_ff |-> dly_flag_ff)
		else $error("delayed flag missed a held request");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
		dly_flag_ff && !dly_clr |=> dly_flag_ff)
		else $error("delayed flag dropped without clear");
	c_flag: cover property (@(posedge core_clk) disable iff (rst)
		dly_flag_ff ##1 !dly_flag_ff);
	c_dn_held: cover property (@(posedge core_clk) disable iff (rst)
		dn_held_ff);
	c_lim_wr: cover property (@(posedge core_clk) disable iff (rst)
		up_we ##1 cfg_rd);
endmodule

// [sclr_map.svh]
`ifndef SCLR_MAP_SVH
`define SCLR_MAP_SVH
// register indices (reached over the configuration access port)
`define SCLR_IDX_UP          1'b0
`define SCLR_IDX_DN          1'b1
// field layout
`define SCLR_CAP_LSB         0
`define SCLR_CAP_MSB         15
`define SCLR_LIM_LSB         16
`define SCLR_LIM_MSB         31
// limit value that turns tracking off
`define SCLR_LIM_OFF         16'hFFFF
// default buffer depths in ADQs
`define SCLR_UP_CAP_DEF      16'h0040
`define SCLR_DN_CAP_DEF      16'h0040
`define SCLR_ZERO16          16'h0000
`endif

// [sclr_pkg.sv]
package sclr_pkg;
	typedef logic [15:0] sclr_adq_t;
	typedef enum logic [1:0] {
		SCLR_KIND_MEMRD,
		SCLR_KIND_IORD,
		SCLR_KIND_CFG,
		SCLR_KIND_WR
	} sclr_kind_t;
endpackage

// [sclr_dir.sv]
`include "sclr_map.svh"
// one direction: limit register, outstanding count, forwarding gate
module sclr_dir #(
	parameter logic [15:0] CAP     = `SCLR_UP_CAP_DEF,
	parameter bit          SEP_BUF = 1'b1
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// limit write
	input  wire logic              lim_we,
	input  wire sclr_pkg::sclr_adq_t lim_wdata,
	// request and completion
	input  wire logic              req_valid,
	input  wire sclr_pkg::sclr_kind_t req_kind,
	input  wire sclr_pkg::sclr_adq_t req_size,
	input  wire logic              cpl_valid,
	input  wire sclr_pkg::sclr_kind_t cpl_kind,
	input  wire sclr_pkg::sclr_adq_t cpl_size,
	// results
	output logic                   fwd_ff,
	output logic                   held_ff,
	output sclr_pkg::sclr_adq_t    limit_ff,
	output sclr_pkg::sclr_adq_t    outst_ff
);
	logic        counted_req;
	logic        counted_cpl;
	logic        track_off;
	logic [16:0] want;
	logic        room;
	sclr_pkg::sclr_adq_t nxt_outst;

	// separate memory buffer counts only memory reads, else all kinds
	assign counted_req = SEP_BUF ? (req_kind == sclr_pkg::SCLR_KIND_MEMRD)
		: 1'b1;
	assign counted_cpl = SEP_BUF ? (cpl_kind == sclr_pkg::SCLR_KIND_MEMRD)
		: 1'b1;
	assign track_off = (limit_ff == `SCLR_LIM_OFF);
	assign want = {1'b0, outst_ff} + {1'b0, req_size};
	assign room = track_off || !counted_req
		|| (want <= {1'b0, limit_ff});

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			limit_ff <= CAP;
		end else if (lim_we) begin
			limit_ff <= lim_wdata;
		end
	end

	always_comb begin
		nxt_outst = outst_ff;
		if (!track_off) begin
			// count frozen while off; stale until old work drains
			if (req_valid && room && counted_req)
				nxt_outst = want[15:0];
			if (cpl_valid && counted_cpl)
				nxt_outst = (nxt_outst >= cpl_size)
					? nxt_outst - cpl_size : `SCLR_ZERO16;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			outst_ff <= `SCLR_ZERO16;
		end else begin
			outst_ff <= nxt_outst;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fwd_ff  <= 1'b0;
			held_ff <= 1'b0;
		end else begin
			fwd_ff  <= req_valid && room;
			held_ff <= req_valid && !room;
		end
	end

	a_over_limit: assert property (@(posedge core_clk) disable iff (rst)
		(req_valid && counted_req && !track_off && want > {1'b0, limit_ff})
		|=> !fwd_ff && held_ff)
		else $error("request over limit was forwarded");
	a_off_frozen: assert property (@(posedge core_clk) disable iff (rst)
		track_off |=> outst_ff == $past(outst_ff))
		else $error("count moved while tracking off");
	a_off_fwd: assert property (@(posedge core_clk) disable iff (rst)
		(req_valid && track_off) |=> fwd_ff)
		else $error("request held while tracking off");
	a_lim_write: assert property (@(posedge core_clk) disable iff (rst)
		lim_we |=> limit_ff == $past(lim_wdata))
		else $error("limit write lost");
	c_held: cover property (@(posedge core_clk) disable iff (rst) held_ff);
	c_fwd: cover property (@(posedge core_clk) disable iff (rst)
		fwd_ff && outst_ff != `SCLR_ZERO16);
endmodule

// [sclr_req_model.sv]
// split requesters and completers on both buses; index 0 up, 1 down
module sclr_req_model (
	// clock
	input  wire logic           core_clk,
	// request and completion strobes, shared kind and size lines
	output logic [1:0]          req_v,
	output logic [1:0]          cpl_v,
	output sclr_pkg::sclr_kind_t kind [2],
	output sclr_pkg::sclr_adq_t  size [2],
	// answers from the bridge
	input  wire logic [1:0]     fwd,
	input  wire logic [1:0]     held
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		req_v = 2'b00;
		cpl_v = 2'b00;
		kind = '{sclr_pkg::SCLR_KIND_MEMRD, sclr_pkg::SCLR_KIND_MEMRD};
		size = '{16'h0000, 16'h0000};
	end
	// a refused request is left for the caller to retry
	task automatic xfer(input bit d, input bit c,
			input sclr_pkg::sclr_kind_t k, input sclr_pkg::sclr_adq_t s,
			output logic [1:0] fh);
		@(negedge core_clk);
		kind[d] = k;
		size[d] = s;
		req_v[d] = !c;
		cpl_v[d] = c;
		@(negedge core_clk);
		req_v[d] = 1'b0;
		cpl_v[d] = 1'b0;
		// released size must not look like the last one
		size[d] = ~s;
		fh = {fwd[d], held[d]};
	endtask
endmodule

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] DN_CAP = 16'h0020;
	typedef struct {
		bit c;
		sclr_pkg::sclr_kind_t k;
		logic [15:0] s;
		logic [1:0] e;
		logic fl;
	} sclr_row_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic cfg_idx = 1'b0;
	logic dly_clr = 1'b0;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_rdata_ff;
	logic dly_flag_ff;
	logic [1:0] req_v, cpl_v, fwd, held, fh;
	sclr_pkg::sclr_kind_t kind [2];
	sclr_pkg::sclr_adq_t size [2];
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	// upstream limit 0x80, memory reads counted, other kinds pass
	sclr_row_t rows [8] = '{
		'{0, sclr_pkg::SCLR_KIND_MEMRD, 16'h0050, 2'b10, 1'b0},
		'{0, sclr_pkg::SCLR_KIND_MEMRD, 16'h0030, 2'b10, 1'b0},
		'{0, sclr_pkg::SCLR_KIND_MEMRD, 16'h0001, 2'b01, 1'b1},
		'{0, sclr_pkg::SCLR_KIND_IORD, 16'h0090, 2'b10, 1'b1},
		'{0, sclr_pkg::SCLR_KIND_CFG, 16'h0090, 2'b10, 1'b1},
		'{0, sclr_pkg::SCLR_KIND_WR, 16'h0090, 2'b10, 1'b1},
		'{1, sclr_pkg::SCLR_KIND_MEMRD, 16'h0030, 2'b00, 1'b1},
		'{0, sclr_pkg::SCLR_KIND_MEMRD, 16'h0030, 2'b10, 1'b1}
	};
	sclr_regs #(.DN_CAP(DN_CAP)) i_sclr_regs (
		.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
		.cfg_rdata_ff(cfg_rdata_ff), .dly_clr(dly_clr),
		.dly_flag_ff(dly_flag_ff), .up_req_valid(req_v[0]),
		.up_req_kind(kind[0]), .up_req_size(size[0]),
		.up_cpl_valid(cpl_v[0]), .up_cpl_kind(kind[0]),
		.up_cpl_size(size[0]), .up_fwd_ff(fwd[0]), .up_held_ff(held[0]),
		.dn_req_valid(req_v[1]), .dn_req_kind(kind[1]),
		.dn_req_size(size[1]), .dn_cpl_valid(cpl_v[1]),
		.dn_cpl_kind(kind[1]), .dn_cpl_size(size[1]),
		.dn_fwd_ff(fwd[1]), .dn_held_ff(held[1]));
	sclr_req_model i_sclr_req_model (
		.core_clk(core_clk), .req_v(req_v), .cpl_v(cpl_v), .kind(kind),
		.size(size), .fwd(fwd), .held(held));
	always #25 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cfg(input bit w, input bit i, input logic [31:0] d,
			input logic [3:0] be);
		@(negedge core_clk);
		cfg_wr = w;
		cfg_rd = !w;
		cfg_idx = i;
		cfg_wdata = d;
		cfg_be = be;
		@(negedge core_clk);
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_wdata = ~d;
	endtask
	task automatic up(input sclr_pkg::sclr_adq_t s, input logic [1:0] e);
		i_sclr_req_model.xfer(0, 0, sclr_pkg::SCLR_KIND_MEMRD, s, fh);
		chk(32'(fh), 32'(e));
	endtask
	task automatic results;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		cfg(0, 0, 32'h0000_0000, 4'h0);
		chk(cfg_rdata_ff, 32'h0040_0040);
		cfg(0, 1, 32'h0000_0000, 4'h0);
		chk(cfg_rdata_ff, {DN_CAP, DN_CAP});
		$display("test reset done");
		cfg(1, 0, 32'h0080_1234, 4'hF);
		cfg(1, 0, 32'h0100_0000, 4'h3);
		cfg(0, 0, 32'h0000_0000, 4'h0);
		chk(cfg_rdata_ff, 32'h0080_0040);
		$display("test write done");
		foreach (rows[n]) begin
			i_sclr_req_model.xfer(0, rows[n].c, rows[n].k, rows[n].s, fh);
			chk(32'(fh), 32'(rows[n].e));
			chk(32'(dly_flag_ff), 32'(rows[n].fl));
		end
		$display("test rows done");
		@(negedge core_clk);
		dly_clr = 1'b1;
		@(negedge core_clk);
		dly_clr = 1'b0;
		chk(32'(dly_flag_ff), 32'h0000_0000);
		i_sclr_req_model.xfer(1, 0, sclr_pkg::SCLR_KIND_MEMRD, 16'h0021, fh);
		chk(32'({fh, dly_flag_ff}), 32'h0000_0002);
		i_sclr_req_model.xfer(1, 0, sclr_pkg::SCLR_KIND_MEMRD, 16'h0020, fh);
		chk(32'(fh), 32'h0000_0002);
		$display("test down done");
		cfg(1, 0, 32'h00B0_0000, 4'hC);
		up(16'h0030, 2'b10);
		cfg(1, 0, 32'hFFFF_0000, 4'hC);
		up(16'hFFFF, 2'b10);
		// count was frozen at 0xB0, so one more no longer fits
		cfg(1, 0, 32'h00B0_0000, 4'hC);
		up(16'h0001, 2'b01);
		$display("test off done");
		// mid-run reset must bring both limits back to capacity
		@(negedge core_clk);
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		cfg(0, 0, 32'h0000_0000, 4'h0);
		chk(cfg_rdata_ff, 32'h0040_0040);
		cfg(0, 1, 32'h0000_0000, 4'h0);
		chk(cfg_rdata_ff, {DN_CAP, DN_CAP});
		chk(32'(dly_flag_ff), 32'h0000_0000);
		$display("test second reset done");
		results();
	end
endmodule
